// *** common/tie_pkg.sv ***
// Shared constants and types for trap and interrupt entry
package tie_pkg;
    localparam int          NUM_IRQ      = 16;
    localparam int          TRAP_BITS    = 5;
    localparam int          NUM_TRAPS    = 32;
    localparam int          ST_WIDTH     = 32;
    localparam int          GIE_POS      = 13;
    localparam logic [31:0] GIE_MASK     = 32'h0000_2000;
    localparam logic [31:0] ST_RESET     = 32'h0000_0000;
    localparam logic [15:0] FLAG_RESET   = 16'h0000;
    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic [4:0]  INDEX_RESET  = 5'h00;
    localparam logic [31:0] PC_RESET     = 32'h0000_0000;

    // CPU write kinds to the flag register
    typedef enum logic [1:0] {
        OP_LOAD = 2'b00,
        OP_AND  = 2'b01,
        OP_OR   = 2'b10,
        OP_XOR  = 2'b11
    } tie_wr_op_t;

    // Entry sequencer states
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CLR  = 2'b01,
        S_VEC  = 2'b10,
        S_RET  = 2'b11
    } tie_state_t;
endpackage : tie_pkg

// *** common/tie_flag_if.sv ***
// Link between the entry sequencer and the flag register
`timescale 1ns/10ps
`default_nettype none
interface tie_flag_if;
    logic [15:0]         set_vec;
    logic [15:0]         clr_vec;
    logic                wr_en;
    tie_pkg::tie_wr_op_t wr_op;
    logic [15:0]         wr_data;
    logic [15:0]         flags;

    modport ctrl (output set_vec, output clr_vec, output wr_en,
                  output wr_op, output wr_data, input flags);
    modport regs (input set_vec, input clr_vec, input wr_en,
                  input wr_op, input wr_data, output flags);
endinterface : tie_flag_if
`default_nettype wire

// *** hdl/tie_flags.sv ***
// Interrupt flag register with CPU write and hardware set
`timescale 1ns/10ps
`default_nettype none
module tie_flags #(
    parameter bit LEGACY = 1'b0
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Flag access
    tie_flag_if.regs    fif
);
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] wr_val;

    always_comb begin
        wr_val = fif.wr_data;
        unique case (fif.wr_op)
            tie_pkg::OP_LOAD: wr_val = fif.wr_data;
            tie_pkg::OP_AND:  wr_val = flags_q & fif.wr_data;
            tie_pkg::OP_OR:   wr_val = flags_q | fif.wr_data;
            tie_pkg::OP_XOR:  wr_val = flags_q ^ fif.wr_data;
        endcase
        flags_d = flags_q & ~fif.clr_vec;
        if (fif.wr_en) begin
            flags_d = wr_val;
        end
        if (!(LEGACY && fif.wr_en)) begin
            flags_d = flags_d | fif.set_vec;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= tie_pkg::FLAG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fif.flags = flags_q;
endmodule : tie_flags
`default_nettype wire

// *** hdl/tie_entry.sv ***
// Trap and interrupt entry and return sequencer
//
// Operation
// - Traps and interrupts share one entry path
// - Traps come only from conditional trap
// - Interrupts come from hardware sources or CPU flag writes
// - Traps ignore global enable and masks
// - Thirty-two trap numbers select vector entries
// - Trap jumps to word in vector entry
// - Trap in decode holds off interrupts
// - True trap clears global interrupt enable
// - Legacy: stalled trap may leave enable cleared
// - True return re-enables global interrupts
// - AND, OR, XOR write flag register
// - Legacy: CPU flag write beats new interrupt
// - Vectoring clears only that source's flag
// - Still-asserted input sets flag again
// - Clear enable, flag, read pointer, vector, push
// - Global enable is status bit 2000h
`timescale 1ns/10ps
`default_nettype none
module tie_entry #(
    parameter bit LEGACY = 1'b0
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // Pipeline: conditional trap
    input  wire logic        TRAP_IN_DECODE,
    input  wire logic        PIPE_STALL,
    input  wire logic        TRAP_EXEC,
    input  wire logic        TRAP_COND_TRUE,
    input  wire logic [4:0]  TRAP_NUM,
    // Pipeline: conditional return
    input  wire logic        RETURN_EXEC,
    input  wire logic        RETURN_COND_TRUE,
    // Pipeline: fetch boundary
    input  wire logic        FETCH_BOUNDARY,
    // Status word write
    input  wire logic        ST_WR,
    input  wire logic [31:0] ST_WDATA,
    // Mask register write
    input  wire logic        MASK_WR,
    input  wire logic [15:0] MASK_WDATA,
    // Flag register write
    input  wire logic        FLAG_WR,
    input  wire logic [1:0]  FLAG_OP,
    input  wire logic [15:0] FLAG_WDATA,
    // Hardware interrupt sources
    input  wire logic [15:0] IRQ_SRC,
    // Vector word from memory
    input  wire logic [31:0] VEC_DATA,
    // Entry sequence strobes
    output logic             ENTRY_START,
    output logic             SP_READ,
    output logic             VEC_READ,
    output logic             PUSH_STATUS,
    output logic             PUSH_RETURN,
    output logic             PC_LOAD,
    output logic [31:0]      PC_TARGET,
    output logic             RETURN_TAKEN,
    // Selected vector
    output logic             VEC_IS_TRAP,
    output logic [4:0]       VEC_INDEX,
    // Register views
    output logic [31:0]      STATUS_WORD,
    output logic [15:0]      IRQ_MASK_REG,
    output logic [15:0]      IRQ_FLAGS,
    output logic             GLOBAL_IRQ_ENABLE
);
    tie_flag_if fif ();

    tie_pkg::tie_state_t state_q;
    tie_pkg::tie_state_t state_d;
    logic [31:0] status_word_q;
    logic [31:0] status_word_d;
    logic [15:0] irq_mask_reg_q;
    logic [15:0] irq_mask_reg_d;
    logic        is_trap_q;
    logic        is_trap_d;
    logic [4:0]  index_q;
    logic [4:0]  index_d;
    logic [31:0] pc_q;
    logic [31:0] pc_d;
    logic [15:0] pending;
    logic        global_irq_enable;
    logic        trap_take;
    logic        irq_take;
    logic        have_irq;
    logic [4:0]  irq_sel;

    // Lowest-numbered pending source has highest priority
    function automatic logic [4:0] pick_lowest(input logic [15:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // One-hot decode of a source index
    function automatic logic [15:0] onehot(input logic [4:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        v[idx[3:0]] = 1'b1;
        return v;
    endfunction

    assign global_irq_enable = status_word_q[tie_pkg::GIE_POS];
    assign pending  = fif.flags & irq_mask_reg_q;
    assign have_irq = |pending;
    assign irq_sel  = pick_lowest(pending);

    assign trap_take = TRAP_EXEC && TRAP_COND_TRUE
                       && (state_q == tie_pkg::S_IDLE);

    // Decode-phase trap holds off
    // A trap in execute also wins over a same-cycle interrupt
    assign irq_take = have_irq && global_irq_enable && FETCH_BOUNDARY
                      && !TRAP_IN_DECODE && !TRAP_EXEC
                      && (state_q == tie_pkg::S_IDLE);

    // Flag register connection
    always_comb begin
        fif.set_vec = IRQ_SRC;
        fif.clr_vec = 16'h0000;
        if (state_q == tie_pkg::S_CLR && !is_trap_q) begin
            fif.clr_vec = onehot(index_q);
        end
        fif.wr_en   = FLAG_WR;
        fif.wr_op   = tie_pkg::tie_wr_op_t'(FLAG_OP);
        fif.wr_data = FLAG_WDATA;
    end

    tie_flags #(
        .LEGACY (LEGACY)
    ) u_flags (
        .clk    (CLK),
        .rst_n  (RSTN),
        .fif    (fif)
    );

    always_comb begin
        state_d   = state_q;
        is_trap_d = is_trap_q;
        index_d   = index_q;
        pc_d      = pc_q;
        unique case (state_q)
            tie_pkg::S_IDLE: begin
                if (trap_take) begin
                    is_trap_d = 1'b1;
                    index_d   = TRAP_NUM;
                    state_d   = tie_pkg::S_CLR;
                end else if (irq_take) begin
                    is_trap_d = 1'b0;
                    index_d   = irq_sel;
                    state_d   = tie_pkg::S_CLR;
                end
            end
            // Clear, then vector, then return push
            tie_pkg::S_CLR: state_d = tie_pkg::S_VEC;
            tie_pkg::S_VEC: state_d = tie_pkg::S_RET;
            tie_pkg::S_RET: begin
                pc_d    = VEC_DATA;
                state_d = tie_pkg::S_IDLE;
            end
        endcase
    end

    // Status word and mask register
    always_comb begin
        status_word_d  = status_word_q;
        irq_mask_reg_d = irq_mask_reg_q;
        if (MASK_WR) begin
            irq_mask_reg_d = MASK_WDATA;
        end
        if (ST_WR) begin
            status_word_d = ST_WDATA;
        end
        if (RETURN_EXEC && RETURN_COND_TRUE) begin
            status_word_d = status_word_d | tie_pkg::GIE_MASK;
        end
        // Legacy stalled trap loses enable
        // Fixed parts only hold off acceptance, enable is untouched
        if (LEGACY && TRAP_IN_DECODE && PIPE_STALL) begin
            status_word_d = status_word_d & ~tie_pkg::GIE_MASK;
        end
        // Entry clears enable, over any load
        if (state_q == tie_pkg::S_CLR) begin
            status_word_d = status_word_d & ~tie_pkg::GIE_MASK;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q        <= tie_pkg::S_IDLE;
            is_trap_q      <= 1'b0;
            index_q        <= tie_pkg::INDEX_RESET;
            pc_q           <= tie_pkg::PC_RESET;
            status_word_q  <= tie_pkg::ST_RESET;
            irq_mask_reg_q <= tie_pkg::MASK_RESET;
        end else begin
            state_q        <= state_d;
            is_trap_q      <= is_trap_d;
            index_q        <= index_d;
            pc_q           <= pc_d;
            status_word_q  <= status_word_d;
            irq_mask_reg_q <= irq_mask_reg_d;
        end
    end

    // Sequence strobes are decoded from state, RETURN_TAKEN from inputs, data from flops
    assign ENTRY_START       = state_q == tie_pkg::S_CLR;
    assign SP_READ           = state_q == tie_pkg::S_CLR;
    assign VEC_READ          = state_q == tie_pkg::S_VEC;
    assign PUSH_STATUS       = state_q == tie_pkg::S_VEC;
    assign PUSH_RETURN       = state_q == tie_pkg::S_RET;
    assign PC_LOAD           = state_q == tie_pkg::S_RET;
    assign PC_TARGET         = pc_q;
    assign RETURN_TAKEN      = RETURN_EXEC && RETURN_COND_TRUE;
    assign VEC_IS_TRAP       = is_trap_q;
    assign VEC_INDEX         = index_q;
    assign STATUS_WORD       = status_word_q;
    assign IRQ_MASK_REG      = irq_mask_reg_q;
    assign IRQ_FLAGS         = fif.flags;
    assign GLOBAL_IRQ_ENABLE = global_irq_enable;
endmodule : tie_entry
`default_nettype wire

// *** tb/tie_assertions.sv ***
// Port checker for the trap and interrupt entry block
`timescale 1ns/10ps
`default_nettype none
module tie_assertions #(
    parameter bit LEGACY = 1'b0
) (
    // Clock, reset, pipeline, flag write, source and vector inputs
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        TRAP_IN_DECODE,
    input wire logic        PIPE_STALL,
    input wire logic        TRAP_EXEC,
    input wire logic        TRAP_COND_TRUE,
    input wire logic [4:0]  TRAP_NUM,
    input wire logic        FETCH_BOUNDARY,
    input wire logic        FLAG_WR,
    input wire logic [15:0] IRQ_SRC,
    input wire logic [31:0] VEC_DATA,
    // Design outputs
    input wire logic        ENTRY_START,
    input wire logic        VEC_READ,
    input wire logic        PUSH_STATUS,
    input wire logic        PUSH_RETURN,
    input wire logic        PC_LOAD,
    input wire logic [31:0] PC_TARGET,
    input wire logic        RETURN_TAKEN,
    input wire logic        VEC_IS_TRAP,
    input wire logic [4:0]  VEC_INDEX,
    input wire logic [31:0] STATUS_WORD,
    input wire logic [15:0] IRQ_MASK_REG,
    input wire logic [15:0] IRQ_FLAGS,
    input wire logic        GLOBAL_IRQ_ENABLE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_vec;
        VEC_READ && PUSH_STATUS;
    endsequence
    sequence s_ret;
        PUSH_RETURN && PC_LOAD;
    endsequence
    a_entry_steps: assert property (ENTRY_START |=> s_vec ##1 s_ret)
        else $error("entry steps out of order");
    a_entry_gie_off: assert property (ENTRY_START |=> !GLOBAL_IRQ_ENABLE)
        else $error("enable still set after entry");
    a_target_load: assert property (PC_LOAD |=> PC_TARGET == $past(VEC_DATA))
        else $error("target differs from vector word");
    a_return_sets: assert property (RETURN_TAKEN && !ENTRY_START
        && !(LEGACY && TRAP_IN_DECODE && PIPE_STALL) |=> GLOBAL_IRQ_ENABLE)
        else $error("return left enable clear");
    a_trap_index: assert property (ENTRY_START && VEC_IS_TRAP |->
        $past(TRAP_EXEC && TRAP_COND_TRUE) && VEC_INDEX == $past(TRAP_NUM))
        else $error("trap entry without matching trap");
    a_irq_cause: assert property (ENTRY_START && !VEC_IS_TRAP |->
        $past(GLOBAL_IRQ_ENABLE && FETCH_BOUNDARY && !TRAP_IN_DECODE
        && (IRQ_FLAGS & IRQ_MASK_REG) != 16'h0000))
        else $error("interrupt taken without cause");
    a_flag_cleared: assert property (ENTRY_START && !VEC_IS_TRAP && !FLAG_WR
        && !IRQ_SRC[VEC_INDEX[3:0]] |=> !IRQ_FLAGS[VEC_INDEX[3:0]])
        else $error("vectored flag not cleared");
    a_gie_bit: assert property (GLOBAL_IRQ_ENABLE == STATUS_WORD[13])
        else $error("enable view differs from status bit");
    // Idle is the absence of ENTRY_START, VEC_READ and PC_LOAD
    a_trap_taken: assert property (TRAP_EXEC && TRAP_COND_TRUE
        && !ENTRY_START && !VEC_READ && !PC_LOAD
        |=> ENTRY_START && VEC_IS_TRAP)
        else $error("true trap not taken");
    a_src_sets_flag: assert property (IRQ_SRC != 16'h0000
        && !(LEGACY && FLAG_WR)
        |=> (IRQ_FLAGS & $past(IRQ_SRC)) == $past(IRQ_SRC))
        else $error("asserted source left its flag clear");
endmodule // tie_assertions
`default_nettype wire

// *** tb/tie_far_model.sv ***
// Far side: interrupt sources and vector memory
`timescale 1ns/10ps
`default_nettype none
module tie_far_model (
    // Clock and bench requests
    input wire logic        clk,
    input wire logic [15:0] fire,
    input wire logic        two,
    // Vector fetch
    input wire logic        pc_load,
    input wire logic        is_trap,
    input wire logic [4:0]  index,
    // Toward the design
    output logic [15:0]     irq_src,
    output logic [31:0]     vec_data
);
    logic        left_q = 1'b0;
    logic [15:0] src_q  = 16'h0000;
    logic [31:0] cnt_q  = 32'h0000_0000;
    assign irq_src = src_q;
    always @(posedge clk) begin
        cnt_q <= cnt_q + 32'h0000_0001;
        if (fire != 16'h0000) begin
            src_q   <= fire;
            left_q  <= two;
        end else if (left_q) begin
            left_q <= 1'b0;
        end else begin
            src_q <= 16'h0000;
        end
    end
    // Running count off-fetch so a late sample is caught
    assign vec_data = pc_load ? {16'hBEEF, 10'h000, is_trap, index} : cnt_q;
endmodule // tie_far_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for trap and interrupt entry
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam bit LEGACY = 1'b0;
    logic        CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        TRAP_IN_DECODE, PIPE_STALL, TRAP_EXEC, TRAP_COND_TRUE;
    logic        RETURN_EXEC, RETURN_COND_TRUE, FETCH_BOUNDARY, two;
    logic        ST_WR, MASK_WR, FLAG_WR, ENTRY_START, SP_READ, VEC_READ;
    logic        PUSH_STATUS, PUSH_RETURN, PC_LOAD, RETURN_TAKEN;
    logic        VEC_IS_TRAP, GLOBAL_IRQ_ENABLE;
    logic [1:0]  FLAG_OP;
    logic [4:0]  TRAP_NUM, VEC_INDEX;
    logic [15:0] MASK_WDATA, FLAG_WDATA, IRQ_SRC, fire, IRQ_MASK_REG, IRQ_FLAGS;
    logic [31:0] ST_WDATA, VEC_DATA, PC_TARGET, STATUS_WORD;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    tie_entry #(.LEGACY(LEGACY)) tie_entry_i (.*);
    tie_far_model tie_far_model_i (.clk(CLK), .fire(fire), .two(two),
        .pc_load(PC_LOAD), .is_trap(VEC_IS_TRAP), .index(VEC_INDEX),
        .irq_src(IRQ_SRC), .vec_data(VEC_DATA));
    always #25 CLK = ~CLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(negedge CLK);
    endtask
    function automatic logic [31:0] word(input logic t, input logic [4:0] i);
        return {16'hBEEF, 10'h000, t, i};
    endfunction
    function automatic logic [15:0] op_res(input logic [1:0] op,
        input logic [15:0] r, input logic [15:0] d);
        case (op)
            2'b00: return d;
            2'b01: return r & d;
            2'b10: return r | d;
            default: return r ^ d;
        endcase
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic do_trap(input logic [4:0] n, input logic c);
        ST_WR = 1'b1;
        ST_WDATA = $urandom;
        TRAP_IN_DECODE = 1'b1;
        PIPE_STALL = 1'b1;
        step();
        {ST_WR, TRAP_IN_DECODE, PIPE_STALL} = 3'h0;
        TRAP_EXEC = 1'b1;
        TRAP_COND_TRUE = c;
        TRAP_NUM = n;
        step();
        TRAP_EXEC = 1'b0;
        chk(ENTRY_START, c);
        chk(SP_READ, c);
        if (c) begin
            chk({VEC_IS_TRAP, VEC_INDEX}, {1'b1, n});
            step(3);
            chk(PC_TARGET, word(1'b1, n));
            chk(GLOBAL_IRQ_ENABLE, 1'b0);
        end else begin
            chk(GLOBAL_IRQ_ENABLE, LEGACY ? 1'b0 : ST_WDATA[13]);
        end
    endtask
    task automatic do_irq;
        logic [15:0] f, m, b, e;
        int lo;
        f = 16'($urandom) | 16'h8000;
        m = 16'($urandom) | 16'h8000;
        lo = 0;
        while (!(f[lo] && m[lo])) lo++;
        b = 16'h0001 << lo;
        e = $urandom_range(1) ? f : f & ~b;
        {MASK_WR, ST_WR, MASK_WDATA, ST_WDATA} = {2'h3, m, tie_pkg::GIE_MASK};
        // Flags left pending by the previous round are loaded to zero
        {FLAG_WR, FLAG_OP, FLAG_WDATA} = 19'h40000;
        fire = f;
        two = 1'($urandom);
        step();
        {MASK_WR, ST_WR, FLAG_WR, fire} = 19'h00000;
        step(3);
        chk(IRQ_FLAGS, f);
        chk(STATUS_WORD, tie_pkg::GIE_MASK);
        {FETCH_BOUNDARY, TRAP_IN_DECODE} = 2'h3;
        step();
        chk(ENTRY_START, 1'b0);
        TRAP_IN_DECODE = 1'b0;
        fire = e[lo] ? b : 16'h0000;
        step();
        {FETCH_BOUNDARY, fire} = 17'h00000;
        chk({VEC_IS_TRAP, VEC_INDEX}, {1'b0, 5'(lo)});
        step();
        chk(IRQ_FLAGS, e);
        chk(GLOBAL_IRQ_ENABLE, 1'b0);
        step(2);
        chk(PC_TARGET, word(1'b0, 5'(lo)));
        {RETURN_EXEC, RETURN_COND_TRUE} = 2'h3;
        step();
        chk(RETURN_TAKEN, 1'b1);
        RETURN_EXEC = 1'b0;
        chk(GLOBAL_IRQ_ENABLE, 1'b1);
    endtask
    task automatic do_flag(input logic [1:0] op);
        logic [15:0] r, d, b;
        r = $urandom;
        d = $urandom;
        b = 16'h0001 << (op * 4);
        {FLAG_WR, FLAG_OP, FLAG_WDATA, fire, two} = {3'h4, r, b, 1'b0};
        step();
        {FLAG_OP, FLAG_WDATA, fire} = {op, d, 16'h0000};
        step();
        // Write strobe stays up; the next call raises it again
        chk(IRQ_FLAGS, op_res(op, r, d) | (LEGACY ? 16'h0000 : b));
    endtask
    initial begin
        {TRAP_IN_DECODE, PIPE_STALL, TRAP_EXEC, TRAP_COND_TRUE} = 4'h0;
        {RETURN_EXEC, RETURN_COND_TRUE, FETCH_BOUNDARY, two} = 4'h0;
        {ST_WR, MASK_WR, FLAG_WR, FLAG_OP, TRAP_NUM} = 10'h000;
        {MASK_WDATA, FLAG_WDATA, fire, ST_WDATA} = 80'h0;
        void'($urandom(13));
        step(6);
        RSTN = 1'b1;
        step();
        for (int i = 0; i < 32; i++) do_trap(5'(i), i[0] | 1'($urandom));
        $display("trap test done");
        repeat (8) do_irq();
        $display("interrupt test done");
        for (int k = 0; k < 4; k++) do_flag(2'(k));
        FLAG_WR = 1'b0;
        $display("flag write test done");
        close_out();
    end
    initial begin
        #(5000 * 50);
        n_mismatch++;
        close_out();
    end
endmodule // tb_top
bind tie_entry tie_assertions #(.LEGACY(LEGACY)) tie_assertions_i (.*);
`default_nettype wire
